// *** bcd_consts.svh ***
// constants of the branch and control decoder: opcodes, fields, lengths, timings
// assumes inclusion by bare name from the package and the design modules
`ifndef BCD_CONSTS_SVH
`define BCD_CONSTS_SVH

// program counter after reset
`define RESET_PC       12'h000
// fixed opcodes of the inherent control group
`define OP_NOP         8'h04
`define OP_INTERRUPT_EXIT        8'h4D
`define OP_RET         8'hCD
`define OP_STOP        8'h6D
`define OP_WAIT        8'hED
// opcode fields
`define F_CLASS        2:0
`define F_KIND         3
`define F_SENSE        4
`define F_HI           7:4
`define F_DISP5        7:3
`define F_IDX_A        5
`define F_IDX_B        6
`define F_IDX_C        7
// low three bits that select each class
`define CL_BR_NZ       3'h0
`define CL_JUMP        3'h1
`define CL_BR_NC       3'h2
`define CL_BIT         3'h3
`define CL_BR_Z        3'h4
`define CL_CTRL        3'h5
`define CL_BR_C        3'h6
// instruction lengths in bytes
`define LEN_1          2'h1
`define LEN_2          2'h2
`define LEN_3          2'h3
// instruction durations in cycles
`define CYC_2          3'h2
`define CYC_4          3'h4
`define CYC_5          3'h5
// sequencing steps
`define STEP_OP        3'h0
`define STEP_B2        3'h1
`define STEP_B3        3'h2
`define STEP_ONE       3'h1
// the long displacement counts from the instruction plus two
`define LONG_BASE      12'h002

`endif

// *** bcd_pkg.sv ***
// types shared by the branch and control decoder modules
// assumes bcd_consts.svh next to it
`include "bcd_consts.svh"

package bcd_pkg;

   typedef enum logic [3:0] {
      CLS_BR_NZ   = 4'h0,
      CLS_BR_NC   = 4'h1,
      CLS_BR_Z    = 4'h2,
      CLS_BR_C    = 4'h3,
      CLS_NOP     = 4'h4,
      CLS_JUMP    = 4'h5,
      CLS_CALL    = 4'h6,
      CLS_BTEST   = 4'h7,
      CLS_BSETCLR = 4'h8,
      CLS_RET     = 4'h9,
      CLS_INTERRUPT_EXIT    = 4'hA,
      CLS_STOP    = 4'hB,
      CLS_WAIT    = 4'hC,
      CLS_ILLEGAL = 4'hD
   } op_class_type;

   typedef struct packed {
      logic [2:0]  step;
      logic [7:0]  opcode;
      logic [7:0]  byte2;
      logic [7:0]  byte3;
      logic        bitval;
      logic [11:0] pc;
      logic [11:0] prog_addr;
      logic        z;
      logic        c;
      logic [7:0]  data_addr;
      logic [7:0]  data_wr_data;
      logic        data_we;
   } core_state_type;

endpackage

// *** op_classify.sv ***
// opcode classifier: class, length in bytes and duration in cycles
// assumes a plain opcode byte; purely combinational
`timescale 1ns/1ps
`default_nettype none
`include "bcd_consts.svh"

module op_classify (
   input  wire logic                 [7:0] opcode,
   output bcd_pkg::op_class_type           cls,
   output logic                      [1:0] len,
   output logic                      [2:0] cycles
);
   import bcd_pkg::*;

   always_comb begin
      cls = CLS_ILLEGAL;
      // [RULE_15] class from low bits
      case (opcode[`F_CLASS])
         `CL_BR_NZ: cls = CLS_BR_NZ;
         `CL_BR_NC: cls = CLS_BR_NC;
         `CL_BR_C:  cls = CLS_BR_C;
         `CL_BR_Z:  cls = (opcode == `OP_NOP) ? CLS_NOP : CLS_BR_Z;
         `CL_JUMP:  cls = opcode[`F_KIND] ? CLS_JUMP : CLS_CALL;
         // [RULE_09] set/clear versus test
         `CL_BIT:   cls = opcode[`F_KIND] ? CLS_BSETCLR : CLS_BTEST;
         `CL_CTRL: begin
            // [RULE_16] unlisted slots illegal
            case (opcode)
               `OP_INTERRUPT_EXIT: cls = CLS_INTERRUPT_EXIT;
               `OP_RET:  cls = CLS_RET;
               `OP_STOP: cls = CLS_STOP;
               `OP_WAIT: cls = CLS_WAIT;
               default:  cls = CLS_ILLEGAL;
            endcase
         end
         default: cls = CLS_ILLEGAL;
      endcase
   end

   always_comb begin
      len    = `LEN_1;
      cycles = `CYC_2;
      case (cls)
         // [RULE_08] two bytes four cycles
         CLS_BSETCLR: begin
            len    = `LEN_2;
            cycles = `CYC_4;
         end
         // [RULE_13] two bytes four cycles
         CLS_JUMP, CLS_CALL: begin
            len    = `LEN_2;
            cycles = `CYC_4;
         end
         // [RULE_04] three bytes five cycles
         CLS_BTEST: begin
            len    = `LEN_3;
            cycles = `CYC_5;
         end
         // [RULE_02] short branches one byte
         // [RULE_11] control ops two cycles
         default: begin
            len    = `LEN_1;
            cycles = `CYC_2;
         end
      endcase
   end

endmodule
`default_nettype wire

// *** pc_offset_adder.sv ***
// program address plus a sign-extended displacement, wrapping in program space
// assumes two's complement displacement narrower than the address
`timescale 1ns/1ps
`default_nettype none

module pc_offset_adder #(
   parameter int ADDR_W = 12,
   parameter int OFF_W  = 5
) (
   input  wire logic [ADDR_W-1:0] base,
   input  wire logic [OFF_W-1:0]  offset,
   output logic      [ADDR_W-1:0] target
);
   logic [ADDR_W-1:0] off_ext;

   assign off_ext = {{(ADDR_W-OFF_W){offset[OFF_W-1]}}, offset};
   assign target  = base + off_ext;

endmodule
`default_nettype wire

// *** branch_control_decoder.sv ***
// sequencer for branch, bit manipulation, control and jump/call instructions
// assumes program and data memories answer combinationally to the addresses
// driven here, and a return stack outside that supplies its top entry
`timescale 1ns/1ps
`default_nettype none
`include "bcd_consts.svh"

// Functional notes
// [RULE_01] branch only when condition holds
// [RULE_02] short branches: 1 byte, 2 cycles
// [RULE_03] 5-bit signed reach -15 to +16
// [RULE_04] bit-clear test: 3 bytes, 5 cycles
// [RULE_05] bit-set test: 3 bytes, 5 cycles
// [RULE_06] tested bit copied into carry
// [RULE_07] 8-bit displacement reach -126 to +129
// [RULE_08] set/clear any byte: 2 bytes, 4 cycles
// [RULE_09] set/clear and test are separate subgroups
// [RULE_10] software avoids read-modify-write on ports
// [RULE_11] control ops 1 byte, 2 cycles
// [RULE_12] watchdog selected turns stop into wait
// [RULE_13] 12-bit jump/call: 2 bytes, 4 cycles
// [RULE_14] direction bit, four-bit span magnitude
// [RULE_15] class selected by opcode low bits
// [RULE_16] bit index/sense in high bits; rest illegal
module branch_control_decoder (
   input  wire logic        mclk,
   input  wire logic        srst,
   output logic      [11:0] prog_addr,
   input  wire logic  [7:0] prog_data,
   output logic       [7:0] data_addr,
   input  wire logic  [7:0] data_rd_data,
   output logic       [7:0] data_wr_data,
   output logic             data_we,
   output logic             stack_push,
   output logic      [11:0] push_addr,
   output logic             stack_pop,
   input  wire logic [11:0] stack_top,
   input  wire logic        interrupt_exit_z,
   input  wire logic        interrupt_exit_c,
   input  wire logic        watchdog_sel,
   output logic             stop_req,
   output logic             wait_req,
   output logic             illegal_op,
   output logic             instr_done,
   output logic      [11:0] pc,
   output logic             flag_z,
   output logic             flag_c
);
   import bcd_pkg::*;

   // ----------------------------------------------------------------
   // state and decode
   // ----------------------------------------------------------------
   core_state_type s_q;
   core_state_type s_d;

   logic [7:0]   op_cur;
   op_class_type cls;
   logic [1:0]   len;
   logic [2:0]   cycles;
   logic         last;
   logic [2:0]   bit_idx;
   logic [11:0] short_target;
   logic [11:0] long_target;
   logic [11:0] long_base;
   logic        taken;
   logic [11:0] next_pc;

   assign op_cur = (s_q.step == `STEP_OP) ? prog_data : s_q.opcode;

   op_classify u_classify (
      .opcode (op_cur),
      .cls    (cls),
      .len    (len),
      .cycles (cycles)
   );

   assign last = (s_q.step == (cycles - `STEP_ONE));

   // [RULE_16] bit index from high bits
   assign bit_idx = {s_q.opcode[`F_IDX_A], s_q.opcode[`F_IDX_B], s_q.opcode[`F_IDX_C]};

   // ----------------------------------------------------------------
   // branch targets
   // ----------------------------------------------------------------
   // [RULE_03] next address plus signed 5-bit
   // [RULE_14] direction and span from opcode
   pc_offset_adder #(
      .ADDR_W (12),
      .OFF_W  (5)
   ) u_short_add (
      .base   (s_q.prog_addr),
      .offset (s_q.opcode[`F_DISP5]),
      .target (short_target)
   );

   assign long_base = s_q.pc + `LONG_BASE;

   // [RULE_07] instruction plus two, signed 8-bit
   pc_offset_adder #(
      .ADDR_W (12),
      .OFF_W  (8)
   ) u_long_add (
      .base   (long_base),
      .offset (s_q.byte3),
      .target (long_target)
   );

   // ----------------------------------------------------------------
   // condition and next program counter
   // ----------------------------------------------------------------
   always_comb begin
      taken   = 1'b0;
      next_pc = s_q.prog_addr;
      // [RULE_01] branch on selected condition
      case (cls)
         CLS_BR_NZ: taken = ~s_q.z;
         CLS_BR_NC: taken = ~s_q.c;
         CLS_BR_Z:  taken = s_q.z;
         CLS_BR_C:  taken = s_q.c;
         // [RULE_04] clear-sense test
         // [RULE_05] set-sense test
         CLS_BTEST: taken = (s_q.bitval == s_q.opcode[`F_SENSE]);
         default:   taken = 1'b0;
      endcase
      case (cls)
         CLS_BR_NZ, CLS_BR_NC, CLS_BR_Z, CLS_BR_C: begin
            if (taken) begin
               next_pc = short_target;
            end
         end
         CLS_BTEST: begin
            if (taken) begin
               next_pc = long_target;
            end
         end
         // [RULE_13] 12-bit absolute target
         CLS_JUMP, CLS_CALL: next_pc = {s_q.opcode[`F_HI], s_q.byte2};
         CLS_RET, CLS_INTERRUPT_EXIT:  next_pc = stack_top;
         default:            next_pc = s_q.prog_addr;
      endcase
   end

   // ----------------------------------------------------------------
   // sequencing
   // ----------------------------------------------------------------
   always_comb begin
      s_d         = s_q;
      s_d.data_we = 1'b0;
      if (s_q.step == `STEP_OP) begin
         s_d.opcode = prog_data;
      end
      if (s_q.step == `STEP_B2 && len != `LEN_1) begin
         s_d.byte2     = prog_data;
         s_d.data_addr = prog_data;
      end
      if (s_q.step == `STEP_B3) begin
         if (len == `LEN_3) begin
            s_d.byte3 = prog_data;
         end
         s_d.bitval = data_rd_data[bit_idx];
         // [RULE_08] read-modify-write of one bit
         if (cls == CLS_BSETCLR) begin
            s_d.data_wr_data          = data_rd_data;
            s_d.data_wr_data[bit_idx] = s_q.opcode[`F_SENSE];
            s_d.data_we               = 1'b1;
         end
      end
      if ({1'b0, s_q.step} < {1'b0, len}) begin
         s_d.prog_addr = s_q.prog_addr + 12'h001;
      end
      if (last) begin
         s_d.step      = `STEP_OP;
         s_d.pc        = next_pc;
         s_d.prog_addr = next_pc;
         // [RULE_06] tested bit into carry
         if (cls == CLS_BTEST) begin
            s_d.c = s_q.bitval;
         end
         // [RULE_11] of the control ops only interrupt exit touches flags
         if (cls == CLS_INTERRUPT_EXIT) begin
            s_d.z = interrupt_exit_z;
            s_d.c = interrupt_exit_c;
         end
      end else begin
         s_d.step = s_q.step + `STEP_ONE;
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         s_q              <= '0;
         s_q.pc           <= `RESET_PC;
         s_q.prog_addr    <= `RESET_PC;
      end else begin
         s_q <= s_d;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign prog_addr    = s_q.prog_addr;
   assign data_addr    = s_q.data_addr;
   assign data_wr_data = s_q.data_wr_data;
   assign data_we      = s_q.data_we;
   assign push_addr    = s_q.prog_addr;
   assign pc           = s_q.pc;
   assign flag_z       = s_q.z;
   assign flag_c       = s_q.c;
   assign instr_done   = last;
   assign stack_push   = last && (cls == CLS_CALL);
   assign stack_pop    = last && (cls == CLS_RET || cls == CLS_INTERRUPT_EXIT);
   // [RULE_12] watchdog forces wait
   assign stop_req     = last && (cls == CLS_STOP) && !watchdog_sel;
   assign wait_req     = last && (cls == CLS_WAIT || (cls == CLS_STOP && watchdog_sel));
   assign illegal_op   = last && (cls == CLS_ILLEGAL);

endmodule
`default_nettype wire

// *** bcd_sva.sv ***
// port checker for the branch and control decoder
// assumes a bind onto branch_control_decoder, one clock, srst high in reset
`timescale 1ns/1ps
`default_nettype none
module bcd_checker (
   input wire logic        mclk,
   input wire logic        srst,
   input wire logic [11:0] prog_addr,
   input wire logic  [7:0] data_rd_data,
   input wire logic  [7:0] data_wr_data,
   input wire logic        data_we,
   input wire logic        stack_push,
   input wire logic [11:0] push_addr,
   input wire logic        stack_pop,
   input wire logic [11:0] stack_top,
   input wire logic        interrupt_exit_z,
   input wire logic        watchdog_sel,
   input wire logic        stop_req,
   input wire logic        wait_req,
   input wire logic        illegal_op,
   input wire logic        instr_done,
   input wire logic [11:0] pc,
   input wire logic        flag_z
);
   default clocking @(posedge mclk); endclocking
   default disable iff (srst);
   // --------------------------------------------------
   // properties
   // --------------------------------------------------
   a_done_pulse: assert property (instr_done |=> !instr_done)
      else $error("done held two cycles");
   a_stop_to_wait: assert property (stop_req |-> instr_done && !watchdog_sel)
      else $error("stop while watchdog selected");
   a_wait_last: assert property (wait_req |-> instr_done && !stop_req)
      else $error("wait outside last cycle");
   a_push_return: assert property (stack_push |-> instr_done && push_addr == pc + 12'h002)
      else $error("bad return address pushed");
   a_pop_target: assert property (stack_pop |=> prog_addr == $past(stack_top))
      else $error("exit did not fetch from stack top");
   a_zero_interrupt_exit: assert property ($changed(flag_z) |-> $past(stack_pop) && flag_z == $past(interrupt_exit_z))
      else $error("zero flag changed outside interrupt exit");
   a_write_pulse: assert property (data_we |-> instr_done ##1 !data_we)
      else $error("bad data write pulse");
   a_one_bit: assert property (data_we |-> $countones(data_wr_data ^ $past(data_rd_data)) <= 1)
      else $error("more than one bit modified");
   a_illegal_step: assert property (illegal_op |=> prog_addr == $past(pc) + 12'h001)
      else $error("illegal opcode did not step by one");
   c_call: cover property (stack_push);
   c_write: cover property (data_we);
   c_stop: cover property (stop_req);
endmodule
`default_nettype wire

// *** prog_mem_model.sv ***
// program and data memory seen by the decoder, answering in the same cycle
// assumes the bench loads bytes through hierarchical access
`timescale 1ns/1ps
`default_nettype none
module prog_mem_model (
   input  wire logic        mclk,
   input  wire logic [11:0] prog_addr,
   output logic       [7:0] prog_data,
   input  wire logic  [7:0] data_addr,
   output logic       [7:0] data_rd_data,
   input  wire logic  [7:0] data_wr_data,
   input  wire logic        data_we
);
   logic [7:0] pmem [4096];
   logic [7:0] dmem [256];
   initial begin
      foreach (pmem[i]) pmem[i] = 8'h04;
      foreach (dmem[i]) dmem[i] = 8'h00;
   end
   assign prog_data    = pmem[prog_addr];
   assign data_rd_data = dmem[data_addr];
   always @(posedge mclk) begin
      if (data_we) begin
         dmem[data_addr] <= data_wr_data;
      end
   end
endmodule
`default_nettype wire

// *** branch_control_decoder_bench.sv ***
// self-checking bench for the branch and control decoder
// assumes prog_mem_model and bcd_checker compiled before it
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin failures++; \
   $display("ERROR %s expected %h seen %h", n, e, g); end end
module branch_control_decoder_bench;
   logic        mclk = 1'b0;
   logic        srst = 1'b1;
   logic [11:0] prog_addr, push_addr, pc;
   logic [11:0] stack_top = 12'h000;
   logic  [7:0] prog_data, data_addr, data_rd_data, data_wr_data;
   logic        data_we, stack_push, stack_pop, stop_req, wait_req;
   logic        illegal_op, instr_done, flag_z, flag_c;
   logic        interrupt_exit_z = 1'b0;
   logic        interrupt_exit_c = 1'b0;
   logic        watchdog_sel = 1'b0;
   int          failures = 0;
   int          compares = 0;
   branch_control_decoder uut (
      .mclk         (mclk),
      .srst         (srst),
      .prog_addr    (prog_addr),
      .prog_data    (prog_data),
      .data_addr    (data_addr),
      .data_rd_data (data_rd_data),
      .data_wr_data (data_wr_data),
      .data_we      (data_we),
      .stack_push   (stack_push),
      .push_addr    (push_addr),
      .stack_pop    (stack_pop),
      .stack_top    (stack_top),
      .interrupt_exit_z       (interrupt_exit_z),
      .interrupt_exit_c       (interrupt_exit_c),
      .watchdog_sel (watchdog_sel),
      .stop_req     (stop_req),
      .wait_req     (wait_req),
      .illegal_op   (illegal_op),
      .instr_done   (instr_done),
      .pc           (pc),
      .flag_z       (flag_z),
      .flag_c       (flag_c)
   );
   prog_mem_model mem (
      .mclk         (mclk),
      .prog_addr    (prog_addr),
      .prog_data    (prog_data),
      .data_addr    (data_addr),
      .data_rd_data (data_rd_data),
      .data_wr_data (data_wr_data),
      .data_we      (data_we)
   );
   always #20 mclk = ~mclk;
   // --------------------------------------------------
   // helpers
   // --------------------------------------------------
   task automatic end_sim;
      if (failures == 0 && compares > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   // load one instruction at the fetch address, run it, judge length and outcome
   task automatic ex(input logic [23:0] code, input logic [11:0] nxt, input int cyc,
                     input logic [2:0] pul, input logic [1:0] zc);
      int          n;
      logic [11:0] a;
      a = prog_addr;
      n = 1;
      {mem.pmem[a], mem.pmem[a + 12'h1], mem.pmem[a + 12'h2]} = code;
      while (instr_done !== 1'b1 && n < 20) begin
         @(negedge mclk);
         n++;
      end
      `CHK("cycles", cyc, n)
      `CHK("pulses", pul, {stop_req, wait_req, illegal_op})
      @(negedge mclk);
      `CHK("next", nxt, prog_addr)
      `CHK("pc", nxt, pc)
      `CHK("flags", zc, {flag_z, flag_c})
   endtask
   // --------------------------------------------------
   // scenarios
   // --------------------------------------------------
   task automatic t_branch_clear;
      ex(24'h780000, 12'h010, 2, 3'h0, 2'h0);
      ex(24'h840000, 12'h011, 2, 3'h0, 2'h0);
      ex(24'h820000, 12'h002, 2, 3'h0, 2'h0);
      ex(24'h860000, 12'h003, 2, 3'h0, 2'h0);
   endtask
   task automatic t_interrupt_exit;
      stack_top = 12'h020;
      interrupt_exit_z = 1'b1;
      interrupt_exit_c = 1'b1;
      ex(24'h4D0000, 12'h020, 2, 3'h0, 2'h3);
   endtask
   task automatic t_branch_set;
      ex(24'h0C0000, 12'h022, 2, 3'h0, 2'h3);
      ex(24'h080000, 12'h023, 2, 3'h0, 2'h3);
      ex(24'h0E0000, 12'h025, 2, 3'h0, 2'h3);
      ex(24'h0A0000, 12'h026, 2, 3'h0, 2'h3);
   endtask
   task automatic t_subroutine;
      stack_top = 12'h040;
      interrupt_exit_z = 1'b0;
      interrupt_exit_c = 1'b0;
      ex(24'hCD0000, 12'h040, 2, 3'h0, 2'h3);
      ex(24'hA10000, 12'hA00, 4, 3'h0, 2'h3);
      ex(24'h198000, 12'h180, 4, 3'h0, 2'h3);
   endtask
   task automatic t_bit_ops;
      mem.dmem[8'h30] = 8'h00;
      mem.dmem[8'h31] = 8'hFF;
      ex(24'hBB3000, 12'h182, 4, 3'h0, 2'h3);
      `CHK("set byte", 8'h20, mem.dmem[8'h30])
      ex(24'h0B3100, 12'h184, 4, 3'h0, 2'h3);
      `CHK("clear byte", 8'hFE, mem.dmem[8'h31])
      ex(24'h033180, 12'h106, 5, 3'h0, 2'h2);
      ex(24'hB3307F, 12'h187, 5, 3'h0, 2'h3);
      ex(24'h133100, 12'h18A, 5, 3'h0, 2'h2);
   endtask
   task automatic t_control;
      ex(24'h050000, 12'h18B, 2, 3'h1, 2'h2);
      watchdog_sel = 1'b1;
      ex(24'h6D0000, 12'h18C, 2, 3'h2, 2'h2);
      watchdog_sel = 1'b0;
      ex(24'h6D0000, 12'h18D, 2, 3'h4, 2'h2);
      ex(24'hED0000, 12'h18E, 2, 3'h2, 2'h2);
      ex(24'h040000, 12'h18F, 2, 3'h0, 2'h2);
   endtask
   initial begin
      repeat (3) @(negedge mclk);
      srst = 1'b0;
      t_branch_clear;
      t_interrupt_exit;
      t_branch_set;
      t_subroutine;
      t_bit_ops;
      t_control;
      end_sim;
   end
   // the whole run needs about 64 cycles; cut it off at 1000
   initial begin
      #40000;
      failures++;
      end_sim;
   end
endmodule
bind branch_control_decoder bcd_checker chk (
   .mclk         (mclk),
   .srst         (srst),
   .prog_addr    (prog_addr),
   .data_rd_data (data_rd_data),
   .data_wr_data (data_wr_data),
   .data_we      (data_we),
   .stack_push   (stack_push),
   .push_addr    (push_addr),
   .stack_pop    (stack_pop),
   .stack_top    (stack_top),
   .interrupt_exit_z       (interrupt_exit_z),
   .watchdog_sel (watchdog_sel),
   .stop_req     (stop_req),
   .wait_req     (wait_req),
   .illegal_op   (illegal_op),
   .instr_done   (instr_done),
   .pc           (pc),
   .flag_z       (flag_z)
);
`default_nettype wire
